// >>> design/rsfifo_pkg.sv
// constants for the rate sample buffer and its register map
// assumes a 100 MHz system clock and APB with 32-bit data
package rsfifo_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] REG_CTRL5_IDX = 8'h24;
  localparam logic [7:0] REG_OUTXL_IDX = 8'h28;
  localparam logic [7:0] REG_OUTZH_IDX = 8'h2d;
  localparam logic [7:0] REG_FCTRL_IDX = 8'h2e;
  localparam logic [7:0] REG_FSRC_IDX = 8'h2f;
  localparam logic [7:0] REG_EVCFG_IDX = 8'h30;
  localparam logic [7:0] REG_EVSRC_IDX = 8'h31;
  localparam int ADDR_W = 10;
  // field positions
  localparam int CTRL5_EN_POS = 6;
  localparam int FCTRL_MODE_LSB = 5;
  localparam int EVCFG_LATCH_POS = 6;
  localparam int EVSRC_IA_POS = 6;
  // reset values
  localparam logic [7:0] CTRL5_RST = 8'h00;
  localparam logic [7:0] FCTRL_RST = 8'h00;
  localparam logic [7:0] EVCFG_RST = 8'h00;
  localparam logic [47:0] OUT_RST = 48'h0;
  // forced source register value in bypass
  localparam logic [7:0] FSRC_BYPASS = 8'h20;
  // buffer geometry
  localparam int DEPTH = 32;
  localparam int SET_W = 48;
  localparam logic [5:0] FULL_CNT = 6'h20;
  // output data rate periods before the trigger bit falls
  localparam logic [1:0] IA_FALL_TICKS = 2'h2;
  typedef enum logic [2:0] {
    RSF_BYPASS = 3'h0,
    RSF_FIFO = 3'h1,
    RSF_STREAM = 3'h2,
    RSF_S2F = 3'h3,
    RSF_B2S = 3'h4
  } rsfifo_mode_e;
endpackage // rsfifo_pkg

// >>> design/rsfifo_top.sv
// rate sample buffer: 32 sets of three-axis data, five modes, APB registers
// assumes rate clock and sample data arrive from outside the clk domain,
// and the event generator's active level comes from logic on clk
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
module rsfifo_top
  import rsfifo_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsfifo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample source, outside the clk domain
  input wire logic odrClk,
  input wire logic [rsfifo_pkg::SET_W-1:0] sampleData,
  // event one generator condition, on clk
  input wire logic eventHit,
  // status levels
  output logic overrunFlag,
  output logic watermarkFlag,
  output logic interruptActive
);
  import rsfifo_pkg::*;

  function automatic logic [7:0] byteOf(input logic [47:0] s,
                                        input logic [2:0] i);
    byteOf = s[{i, 3'h0} +: 8];
  endfunction

  // input synchronisers
  logic odrS1_q;
  logic odrS2_q;
  logic odrS3_q;
  logic [SET_W-1:0] smpS1_q;
  logic [SET_W-1:0] smpS2_q;
  always_ff @(posedge clk)
  begin
    odrS1_q <= odrClk;
    odrS2_q <= odrS1_q;
    odrS3_q <= odrS2_q;
  end

  // sample data, two stages
  always_ff @(posedge clk)
  begin
    smpS1_q <= sampleData;
    smpS2_q <= smpS1_q;
  end
  wire tick = odrS2_q & ~odrS3_q;

  // registers
  logic [7:0] ctrl5_q;
  logic [7:0] fctrl_q;
  logic [7:0] evcfg_q;
  logic [SET_W-1:0] mem_q [DEPTH];
  logic [4:0] wrPtr_q;
  logic [4:0] rdPtr_q;
  logic [5:0] count_q;
  logic overrun_flag_q;
  logic done_q;
  logic [SET_W-1:0] lastOut_q;
  logic [SET_W-1:0] serBuf_q;
  logic ia_q;
  logic iaClrPend_q;
  logic [1:0] iaTicks_q;
  logic iaPrev_q;
  logic spare_q;
  logic [31:0] prdata_q;
  logic slverr_q;

  // apb decode
  wire [7:0] idx = paddr[ADDR_W-1:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire isOut = (idx >= REG_OUTXL_IDX) && (idx <= REG_OUTZH_IDX);
  wire mapped = (idx == REG_CTRL5_IDX) || isOut || (idx == REG_FCTRL_IDX)
    || (idx == REG_FSRC_IDX) || (idx == REG_EVCFG_IDX)
    || (idx == REG_EVSRC_IDX);
  wire wrDone = access & pwrite & mapped;
  wire rdDone = access & ~pwrite;
  wire [7:0] wrByte = pwdata[7:0];

  // register hits
  wire hitCtrl5 = idx == REG_CTRL5_IDX;
  wire hitFctrl = idx == REG_FCTRL_IDX;
  wire hitEvcfg = idx == REG_EVCFG_IDX;
  wire hitEvsrc = idx == REG_EVSRC_IDX;

  // mode decode
  wire enable = ctrl5_q[CTRL5_EN_POS];
  wire [2:0] modeSel = fctrl_q[FCTRL_MODE_LSB +: 3];
  wire [4:0] wtmLevel = fctrl_q[4:0];
  wire latchEv = evcfg_q[EVCFG_LATCH_POS];
  wire modeFifo = modeSel == RSF_FIFO;
  wire modeStream = modeSel == RSF_STREAM;
  wire modeS2f = modeSel == RSF_S2F;
  wire modeB2s = modeSel == RSF_B2S;
  wire modeBypass = ~(modeFifo | modeStream | modeS2f | modeB2s);
  // trigger rising on a full buffer earns one more sample
  wire iaRise = ia_q & ~iaPrev_q;
  wire spareSet = iaRise & modeS2f & overrun_flag_q;
  wire frozen = modeS2f & ia_q & overrun_flag_q & ~spare_q & ~spareSet;
  wire b2sIdle = modeB2s & ~ia_q;
  wire bypassLike = ~enable | modeBypass | b2sIdle;
  wire fifoLike = (modeFifo & ~done_q) | frozen;
  wire streamLike = (modeStream | (modeS2f & ~frozen) | (modeB2s & ia_q));

  // writes that select bypass clear at once
  wire ctrlWr = wrDone & (idx == REG_FCTRL_IDX);
  wire byWr = ctrlWr & (wrByte[FCTRL_MODE_LSB +: 3] == RSF_BYPASS);
  wire clearBuf = byWr | (tick & bypassLike);

  // buffer movement
  wire full = count_q == FULL_CNT;
  wire nonEmpty = count_q != 6'h0;
  wire outRd = rdDone & (idx == REG_OUTXL_IDX);
  wire pop = outRd & enable & ~bypassLike & nonEmpty;
  wire fifoRoom = ~full | pop;
  wire push = tick & ~clearBuf
    & ((fifoLike & fifoRoom & ~frozen) | streamLike);
  wire drop = push & full & ~pop;
  wire advance = pop | drop;
  wire [5:0] countInc = count_q + 6'h1;
  wire [5:0] countDec = count_q - 6'h1;
  wire [5:0] countNext = clearBuf ? 6'h0
    : (push & ~pop & ~drop) ? countInc
    : (pop & ~push) ? countDec : count_q;
  wire reachFull = push & ~pop & (countNext == FULL_CNT);
  wire ovrnSet = ~clearBuf & (reachFull | drop);

  // oldest set view
  wire [SET_W-1:0] oldest = mem_q[rdPtr_q];
  wire [SET_W-1:0] outView = (enable & ~bypassLike & nonEmpty)
    ? oldest : lastOut_q;
  wire [SET_W-1:0] lastNext = (~enable & tick) ? smpS2_q : outView;

  // source register
  wire [4:0] fss = full ? 5'h1f : count_q[4:0];
  wire wtmNow = fss > wtmLevel;
  wire [7:0] srcVal = (modeBypass | ~enable) ? FSRC_BYPASS
    : {wtmNow, overrun_flag_q, ~nonEmpty, fss};

  // read mux
  wire [2:0] outByte = 3'(idx - REG_OUTXL_IDX);
  wire [7:0] outData = (idx == REG_OUTXL_IDX)
    ? byteOf(outView, 3'h0) : byteOf(serBuf_q, outByte);
  wire [7:0] evsrcVal = {1'b0, ia_q, 6'h0};
  wire [7:0] rdByte = (idx == REG_CTRL5_IDX) ? ctrl5_q
    : isOut ? outData
    : (idx == REG_FCTRL_IDX) ? fctrl_q
    : (idx == REG_FSRC_IDX) ? srcVal
    : (idx == REG_EVCFG_IDX) ? evcfg_q
    : (idx == REG_EVSRC_IDX) ? evsrcVal : 8'h0;

  // event one active bit
  wire evsrcRd = rdDone & hitEvsrc;
  wire iaFall = iaClrPend_q & tick & (iaTicks_q == IA_FALL_TICKS - 2'h1);

  // apb outputs
  always_ff @(posedge clk)
  begin
    if (srst)
      prdata_q <= 32'h0;
    else if (setup)
      prdata_q <= {24'h0, rdByte};
  end

  // unmapped index flag
  always_ff @(posedge clk)
  begin
    if (srst)
      slverr_q <= 1'b0;
    else if (setup)
      slverr_q <= ~mapped;
  end
  assign prdata = prdata_q;
  assign pready = access;
  assign pslverr = access & slverr_q;

  // enable control
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl5_q <= CTRL5_RST;
    else if (wrDone & hitCtrl5)
      ctrl5_q <= wrByte;
  end

  // mode control
  always_ff @(posedge clk)
  begin
    if (srst)
      fctrl_q <= FCTRL_RST;
    else if (wrDone & hitFctrl)
      fctrl_q <= wrByte;
  end

  // event configuration
  always_ff @(posedge clk)
  begin
    if (srst)
      evcfg_q <= EVCFG_RST;
    else if (wrDone & hitEvcfg)
      evcfg_q <= wrByte;
  end

  // sample storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= smpS2_q;
  end

  // write index
  always_ff @(posedge clk)
  begin
    if (srst | clearBuf)
      wrPtr_q <= 5'h0;
    else if (push)
      wrPtr_q <= wrPtr_q + 5'h1;
  end

  // read index
  always_ff @(posedge clk)
  begin
    if (srst | clearBuf)
      rdPtr_q <= 5'h0;
    else if (advance)
      rdPtr_q <= rdPtr_q + 5'h1;
  end

  // stored set count, cleared through countNext
  always_ff @(posedge clk)
  begin
    if (srst)
      count_q <= 6'h0;
    else
      count_q <= countNext;
  end

  // overrun flag: a set wins over a same-cycle pop
  always_ff @(posedge clk)
  begin
    if (srst)
      overrun_flag_q <= 1'b0;
    else if (ovrnSet)
      overrun_flag_q <= 1'b1;
    else if (pop | clearBuf)
      overrun_flag_q <= 1'b0;
  end

  // fill-and-stop halt
  always_ff @(posedge clk)
  begin
    if (srst)
      done_q <= 1'b0;
    else if (ctrlWr | clearBuf)
      done_q <= 1'b0;
    else if (modeFifo & reachFull)
      done_q <= 1'b1;
  end

  // one extra sample after a trigger on a full buffer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      iaPrev_q <= 1'b0;
      spare_q <= 1'b0;
    end
    else
    begin
      iaPrev_q <= ia_q;
      if (spareSet)
        spare_q <= 1'b1;
      else if (clearBuf | push | ~(modeS2f & ia_q))
        spare_q <= 1'b0;
    end
  end

  // output register: last shown set, or the newest sample while disabled
  always_ff @(posedge clk)
  begin
    if (srst)
      lastOut_q <= OUT_RST;
    else
      lastOut_q <= lastNext;
  end

  // serial output copy of the popped set
  always_ff @(posedge clk)
  begin
    if (srst)
      serBuf_q <= OUT_RST;
    else if (outRd)
      serBuf_q <= outView;
  end

  // trigger bit: follows the event, or latches until read plus two ticks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ia_q <= 1'b0;
      iaClrPend_q <= 1'b0;
      iaTicks_q <= 2'h0;
    end
    else if (~latchEv)
    begin
      ia_q <= eventHit;
      iaClrPend_q <= 1'b0;
      iaTicks_q <= 2'h0;
    end
    else
    begin
      if (eventHit)
        ia_q <= 1'b1;
      else if (iaFall)
        ia_q <= 1'b0;
      if (evsrcRd & ia_q)
      begin
        iaClrPend_q <= 1'b1;
        iaTicks_q <= 2'h0;
      end
      else if (iaFall)
      begin
        iaClrPend_q <= 1'b0;
        iaTicks_q <= 2'h0;
      end
      else if (iaClrPend_q & tick)
        iaTicks_q <= iaTicks_q + 2'h1;
    end
  end

  // status levels
  assign overrunFlag = overrun_flag_q;
  assign watermarkFlag = wtmNow & enable & ~modeBypass;
  assign interruptActive = ia_q;
endmodule // rsfifo_top

// >>> verif/rsfifo_chk.sv
// checker on the buffer top ports: apb timing, read data, bypass state
// assumes binding into rsfifo_top; mode is tracked from apb writes
module rsfifo_chk
  import rsfifo_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic srst,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [rsfifo_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // status
  input logic overrunFlag,
  input logic watermarkFlag
);
  logic acc;
  logic rdAcc;
  logic [2:0] mode_q;
  assign acc = psel && penable;
  assign rdAcc = acc && !pwrite;
  always_ff @(posedge clk)
  begin
    if (srst)
      mode_q <= 3'h0;
    else if (acc && pwrite && paddr[9:2] == 8'h2e)
      mode_q <= pwdata[7:5];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rdy; pready == acc; endproperty
  a_rdy: assert property (p_rdy) else $error("pready wrong");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_hold; acc |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_unm; rdAcc && pslverr |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hi; prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("prdata upper bits set");
  property p_byp;
    rdAcc && paddr[9:2] == 8'h2f && mode_q == 3'h0 |-> prdata[7:0] == 8'h20;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass status");
  property p_clr;
    acc && pwrite && paddr[9:2] == 8'h2e && pwdata[7:5] == 3'h0
      |=> !overrunFlag [*2];
  endproperty
  a_clr: assert property (p_clr) else $error("bypass kept overrun");
  property p_wtm; mode_q == 3'h0 |-> !watermarkFlag; endproperty
  a_wtm: assert property (p_wtm) else $error("watermark in bypass");
endmodule // rsfifo_chk

bind rsfifo_top rsfifo_chk u_chk (.*);

// >>> verif/rsfifo_src.sv
// sample source: odr clock and random sample sets
// assumes clk at 100 MHz; odr clock runs only while run is high
module rsfifo_src (
  // clock and control
  input logic clk,
  input logic run,
  // link
  output logic odrClk,
  output logic [47:0] sampleData
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 9207;
  logic [2:0] cnt_q = 3'h0;
  initial odrClk = 1'b0;
  initial sampleData = 48'h0;
  // data changes 4 clk away from each rise, holds while idle
  always @(posedge clk)
  begin
    cnt_q <= run ? cnt_q + 3'h1 : 3'h0;
    if (!run || cnt_q == 3'h0)
      odrClk <= 1'b0;
    else if (cnt_q == 3'h4)
      odrClk <= 1'b1;
    if (run && cnt_q == 3'h0)
      sampleData <= 48'({$random(seed), $random(seed)});
  end
endmodule // rsfifo_src

// >>> verif/test_rsfifo_top.sv
// bench for the rate sample buffer: apb host and queue model
// assumes rsfifo_src feeds the link and the checker is bound
module test_rsfifo_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsfifo_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, odrClk, eventHit = 0, run = 0;
  logic overrunFlag, watermarkFlag, interruptActive;
  logic [SET_W-1:0] sampleData, got;
  logic [SET_W-1:0] q[$];
  int err_count = 0, compares = 0, m = 0;
  always #5 clk = ~clk;
  rsfifo_top u_dut (.*);
  rsfifo_src u_src (.*);
  // model: fill-and-stop keeps first 32, stream keeps last 32
  always @(posedge odrClk)
  begin
    if ((m == 1 && q.size() < DEPTH) || m == 2)
      q.push_back(sampleData);
    if (q.size() > DEPTH)
      void'(q.pop_front());
  end
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ticks(input int k);
    run <= 1;
    repeat (k) @(posedge odrClk);
    run <= 0;
    repeat (8) @(posedge clk);
  endtask
  task automatic drain(input int k);
    for (int s = 0; s < k; s++)
    begin
      for (int b = 0; b < 6; b++)
      begin
        apb(0, 8'h28 + 8'(b), 8'h0);
        got[8*b +: 8] = rd[7:0];
      end
      chk(got, q.pop_front());
    end
  endtask
  task automatic src(input logic [7:0] e);
    apb(0, 8'h2f, 8'h0);
    chk(rd[7:0], e);
  endtask
  initial
  begin
    #300000;
    err_count++;
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 0;
    src(8'h20);
    apb(1, 8'h24, 8'h40);
    ticks(3);
    src(8'h20);
    apb(0, 8'h50, 8'h0);
    chk(rd, 0);
    m = 1;
    apb(1, 8'h2e, 8'h20);
    ticks(36);
    src(8'hdf);
    chk({overrunFlag, watermarkFlag}, 2'b11);
    drain(1);
    chk(overrunFlag, 0);
    drain(31);
    src(8'h20);
    apb(1, 8'h2e, 8'h00);
    m = 2;
    apb(1, 8'h2e, 8'h40);
    ticks(40);
    chk(overrunFlag, 1);
    drain(2);
    apb(1, 8'h2e, 8'h00);
    src(8'h20);
    q.delete();
    m = 1;
    eventHit <= 1;
    apb(1, 8'h2e, 8'h60);
    ticks(36);
    src(8'hdf);
    drain(32);
    eventHit <= 0;
    apb(1, 8'h2e, 8'h00);
    q.delete();
    m = 2;
    apb(1, 8'h2e, 8'h60);
    ticks(34);
    eventHit <= 1;
    ticks(1);
    m = 0;
    ticks(2);
    src(8'hdf);
    drain(32);
    apb(1, 8'h2e, 8'h00);
    m = 0;
    eventHit <= 0;
    apb(1, 8'h2e, 8'h80);
    ticks(3);
    src(8'h20);
    eventHit <= 1;
    ticks(4);
    apb(0, 8'h2f, 8'h0);
    chk(rd[5], 0);
    eventHit <= 0;
    ticks(3);
    src(8'h20);
    apb(1, 8'h2e, 8'h00);
    apb(1, 8'h30, 8'h40);
    eventHit <= 1;
    @(posedge clk);
    eventHit <= 0;
    repeat (2) @(posedge clk);
    chk(interruptActive, 1);
    apb(0, 8'h31, 8'h0);
    chk(rd[6], 1);
    ticks(1);
    chk(interruptActive, 1);
    ticks(1);
    chk(interruptActive, 0);
    test_done;
  end
endmodule // test_rsfifo_top
